/* File: common/sec_defines.svh */
// Offsets, field positions, reset values and timing counts of the serial memory controller
`ifndef SEC_DEFINES_SVH
`define SEC_DEFINES_SVH
`define SEC_CMD_OFS 8'h00
`define SEC_DATA_OFS 8'h04
`define SEC_IRQ_STAT_OFS 8'h08
`define SEC_IRQ_MASK_OFS 8'h0C
`define SEC_BUSY_BIT 31
`define SEC_CMD_LSB 28
`define SEC_CMD_MSB 30
`define SEC_TMO_BIT 9
`define SEC_LOADED_BIT 8
`define SEC_ADDR_RST 8'h00
`define SEC_CLK_MHZ 10
`define SEC_TMO_MS 30
`define SEC_TMO_CYC (`SEC_TMO_MS * 1000 * `SEC_CLK_MHZ)
`define SEC_SK_DIV 4
`endif

/* File: common/sec_pkg.sv */
// Types of the serial memory controller
`default_nettype none
package sec_pkg;
  typedef enum logic [2:0] {
    SEC_CMD_READ = 3'h0,
    SEC_CMD_LOCK = 3'h1,
    SEC_CMD_UNLOCK = 3'h2,
    SEC_CMD_WRITE = 3'h3,
    SEC_CMD_WRALL = 3'h4,
    SEC_CMD_ERASE = 3'h5,
    SEC_CMD_ERALL = 3'h6,
    SEC_CMD_RELOAD = 3'h7
  } sec_cmd_t;
  typedef enum logic [3:0] {
    SEC_ST_IDLE = 4'b0001,
    SEC_ST_SHIFT = 4'b0010,
    SEC_ST_WAIT = 4'b0100,
    SEC_ST_DONE = 4'b1000
  } sec_state_t;
endpackage : sec_pkg
`default_nettype wire

/* File: rtl/sec_shifter.sv */
// Serial shifter: clock divider, frame output and input capture
`timescale 1ns/1ns
`default_nettype none
`include "sec_defines.svh"
module sec_shifter #(
  parameter int unsigned LEN_W = 5
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [26:0] frame,
  input wire logic [LEN_W-1:0] len,
  input wire logic din,
  output logic done,
  output logic [7:0] rx,
  output logic sk,
  output logic dout
);
  logic [26:0] sh_r;
  logic [LEN_W-1:0] cnt_r;
  logic [2:0] div_r;
  logic act_r;
  logic [7:0] rx_r;
  logic sk_r;
  logic done_r;
  // ==========================================
  // Shift engine
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sh_r <= '0;
      cnt_r <= '0;
      div_r <= 3'h0;
      act_r <= 1'b0;
      sk_r <= 1'b0;
      rx_r <= 8'h00;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (start && !act_r) begin
        sh_r <= frame;
        cnt_r <= len;
        act_r <= 1'b1;
        div_r <= 3'h0;
      end else if (act_r) begin
        div_r <= (div_r == 3'(`SEC_SK_DIV - 1)) ? 3'h0 : div_r + 3'h1;
        if (div_r == 3'(`SEC_SK_DIV/2 - 1)) begin
          sk_r <= 1'b1;
          rx_r <= {rx_r[6:0], din};
        end
        if (div_r == 3'(`SEC_SK_DIV - 1)) begin
          sk_r <= 1'b0;
          sh_r <= {sh_r[25:0], 1'b0};
          if (cnt_r == LEN_W'(1)) begin
            act_r <= 1'b0;
            done_r <= 1'b1;
          end
          cnt_r <= cnt_r - LEN_W'(1);
        end
      end
    end
  end
  assign done = done_r;
  assign rx = rx_r;
  assign sk = sk_r;
  assign dout = sh_r[26];
endmodule : sec_shifter
`default_nettype wire

/* File: rtl/sec_ctrl.sv */
// Serial memory command controller with AHB-Lite register slave
// What this block does
// - Abandon unanswered memory operation after 30 ms and return to idle.
// - Set time-out status on abandonment; software clears it by writing one.
// - With data line idling high, no time-out; busy clears after shifting.
// - With data line low, only erase and write commands time out; the code times out only those issued after unlock.
// - Set address-loaded bit after successful station address read or reload.
// - Take 8-bit byte address from low command field, read/write, reset zero.
// - Erase and write allowed after unlock until lock command or power loss.
//
// Added by the designer: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "sec_defines.svh"
module sec_ctrl #(
  parameter int unsigned TMO_CYC = `SEC_TMO_CYC
) (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic HSEL,
  input wire logic [7:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  output logic MEM_CS,
  output logic MEM_SK,
  output logic MEM_DO,
  input wire logic SERIAL_MEM_DATA_PIN,
  output logic IRQ
);
  logic din_s1_r, din_s2_r;
  logic wr_ph_r, rd_ph_r;
  logic [7:0] adr_ph_r;
  logic [7:0] addr_r;
  logic [7:0] data_r;
  logic [2:0] cmd_r;
  logic busy_r, tmo_r, loaded_r, unlock_r;
  logic boot_r;
  logic [1:0] stat_r, mask_r;
  sec_pkg::sec_state_t st_r;
  logic [31:0] tcnt_r;
  logic sh_start, sh_done;
  logic [7:0] sh_rx;
  logic [26:0] frame;
  logic [4:0] flen;
  logic cmd_wr, tmo_ev, load_ev, wr_class, needs_wait;
  logic [31:0] rdata_nxt;
  logic [31:0] rdata_r;
  // ==========================================
  // Pin synchroniser
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      din_s1_r <= 1'b0;
      din_s2_r <= 1'b0;
    end else begin
      din_s1_r <= SERIAL_MEM_DATA_PIN;
      din_s2_r <= din_s1_r;
    end
  end
  // ==========================================
  // AHB-Lite address phase capture
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      wr_ph_r <= 1'b0;
      rd_ph_r <= 1'b0;
      adr_ph_r <= 8'h00;
    end else if (HREADY) begin
      wr_ph_r <= HSEL && HTRANS[1] && HWRITE;
      rd_ph_r <= HSEL && HTRANS[1] && !HWRITE;
      adr_ph_r <= HADDR;
    end
  end
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign cmd_wr = wr_ph_r && (adr_ph_r == `SEC_CMD_OFS);
  // ==========================================
  // Command and data registers
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      addr_r <= `SEC_ADDR_RST;
      cmd_r <= 3'h0;
      data_r <= 8'h00;
    end else begin
      if (boot_r) begin
        cmd_r <= sec_pkg::SEC_CMD_RELOAD;
      end else if (cmd_wr && !busy_r) begin
        addr_r <= HWDATA[7:0];
        cmd_r <= HWDATA[`SEC_CMD_MSB:`SEC_CMD_LSB];
      end
      if (wr_ph_r && adr_ph_r == `SEC_DATA_OFS && !busy_r)
        data_r <= HWDATA[7:0];
      else if (sh_done && cmd_r == sec_pkg::SEC_CMD_READ)
        data_r <= sh_rx;
    end
  end
  // ==========================================
  // Sequencer
  assign wr_class = (cmd_r == sec_pkg::SEC_CMD_WRITE) || (cmd_r == sec_pkg::SEC_CMD_WRALL) ||
                    (cmd_r == sec_pkg::SEC_CMD_ERASE) || (cmd_r == sec_pkg::SEC_CMD_ERALL);
  assign needs_wait = wr_class && unlock_r;
  assign sh_start = (st_r == sec_pkg::SEC_ST_SHIFT);
  always_comb begin
    frame = {1'b1, 2'b10, addr_r, data_r, 8'h00};
    flen = 5'd11;
    case (cmd_r)
      sec_pkg::SEC_CMD_READ: begin
        frame = {1'b1, 2'b10, addr_r, 16'h0000};
        flen = 5'd19;
      end
      sec_pkg::SEC_CMD_LOCK: frame = {1'b1, 2'b00, 8'h00, 16'h0000};
      sec_pkg::SEC_CMD_UNLOCK: frame = {1'b1, 2'b00, 8'hC0, 16'h0000};
      sec_pkg::SEC_CMD_WRITE: begin
        frame = {1'b1, 2'b01, addr_r, data_r, 8'h00};
        flen = 5'd19;
      end
      sec_pkg::SEC_CMD_WRALL: begin
        frame = {1'b1, 2'b00, 8'h40, data_r, 8'h00};
        flen = 5'd19;
      end
      sec_pkg::SEC_CMD_ERASE: frame = {1'b1, 2'b11, addr_r, 16'h0000};
      sec_pkg::SEC_CMD_ERALL: frame = {1'b1, 2'b00, 8'h80, 16'h0000};
      sec_pkg::SEC_CMD_RELOAD: begin
        frame = {1'b1, 2'b10, 8'h00, 16'h0000};
        flen = 5'd19;
      end
      default: frame = '0;
    endcase
  end
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      st_r <= sec_pkg::SEC_ST_IDLE;
      busy_r <= 1'b0;
      tcnt_r <= 32'h0;
    end else begin
      case (st_r)
        sec_pkg::SEC_ST_IDLE: begin
          if (boot_r) begin
            st_r <= sec_pkg::SEC_ST_SHIFT;
            busy_r <= 1'b1;
          end else if (cmd_wr && !busy_r && HWDATA[`SEC_BUSY_BIT]) begin
            st_r <= sec_pkg::SEC_ST_SHIFT;
            busy_r <= 1'b1;
          end
        end
        sec_pkg::SEC_ST_SHIFT: st_r <= sec_pkg::SEC_ST_DONE;
        sec_pkg::SEC_ST_DONE: begin
          if (sh_done) begin
            tcnt_r <= 32'h0;
            if (needs_wait) st_r <= sec_pkg::SEC_ST_WAIT;
            else begin
              st_r <= sec_pkg::SEC_ST_IDLE;
              busy_r <= 1'b0;
            end
          end
        end
        sec_pkg::SEC_ST_WAIT: begin
          tcnt_r <= tcnt_r + 32'h1;
          if (din_s2_r) begin
            st_r <= sec_pkg::SEC_ST_IDLE;
            busy_r <= 1'b0;
          end else if (tcnt_r >= TMO_CYC - 1) begin
            st_r <= sec_pkg::SEC_ST_IDLE;
            busy_r <= 1'b0;
          end
        end
        default: begin
          st_r <= sec_pkg::SEC_ST_IDLE;
          busy_r <= 1'b0;
        end
      endcase
    end
  end
  assign tmo_ev = (st_r == sec_pkg::SEC_ST_WAIT) && !din_s2_r && (tcnt_r >= TMO_CYC - 1);
  assign load_ev = (st_r == sec_pkg::SEC_ST_DONE) && sh_done &&
                   (cmd_r == sec_pkg::SEC_CMD_RELOAD) && (sh_rx != 8'hFF);
  // ==========================================
  // Power-up station address load
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) boot_r <= 1'b1;
    else boot_r <= 1'b0;
  end
  // ==========================================
  // Write unlock state
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) unlock_r <= 1'b0;
    else if ((st_r == sec_pkg::SEC_ST_DONE) && sh_done) begin
      if (cmd_r == sec_pkg::SEC_CMD_UNLOCK) unlock_r <= 1'b1;
      else if (cmd_r == sec_pkg::SEC_CMD_LOCK) unlock_r <= 1'b0;
    end
  end
  // ==========================================
  // Status flags, set wins over clear
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      tmo_r <= 1'b0;
      loaded_r <= 1'b0;
    end else begin
      if (tmo_ev) tmo_r <= 1'b1;
      else if (cmd_wr && HWDATA[`SEC_TMO_BIT]) tmo_r <= 1'b0;
      if (load_ev) loaded_r <= 1'b1;
      else if (cmd_wr && HWDATA[`SEC_LOADED_BIT]) loaded_r <= 1'b0;
    end
  end
  // ==========================================
  // Interrupt status and mask
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      stat_r <= 2'h0;
      mask_r <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if ((i == 0) ? tmo_ev : load_ev) stat_r[i] <= 1'b1;
        else if (wr_ph_r && adr_ph_r == `SEC_IRQ_STAT_OFS && HWDATA[i]) stat_r[i] <= 1'b0;
      end
      if (wr_ph_r && adr_ph_r == `SEC_IRQ_MASK_OFS) mask_r <= HWDATA[1:0];
    end
  end
  assign IRQ = |(stat_r & mask_r);
  // ==========================================
  // Read data
  always_comb begin
    rdata_nxt = 32'h0;
    case (HADDR)
      `SEC_CMD_OFS: rdata_nxt = {busy_r, cmd_r, 18'h0, tmo_r, loaded_r, addr_r};
      `SEC_DATA_OFS: rdata_nxt = {24'h0, data_r};
      `SEC_IRQ_STAT_OFS: rdata_nxt = {30'h0, stat_r};
      `SEC_IRQ_MASK_OFS: rdata_nxt = {30'h0, mask_r};
      default: rdata_nxt = 32'h0;
    endcase
  end
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) rdata_r <= 32'h0;
    else if (HREADY && HSEL && HTRANS[1] && !HWRITE) rdata_r <= rdata_nxt;
  end
  assign HRDATA = rdata_r;
  assign MEM_CS = (st_r == sec_pkg::SEC_ST_DONE) || (st_r == sec_pkg::SEC_ST_WAIT);
  // ==========================================
  // Shifter
  sec_shifter #(.LEN_W(5)) u_shift (
    .clk(CLK_SYS),
    .rst_n(RST_N),
    .start(sh_start),
    .frame(frame),
    .len(flen),
    .din(din_s2_r),
    .done(sh_done),
    .rx(sh_rx),
    .sk(MEM_SK),
    .dout(MEM_DO)
  );
  // ==========================================
  // Assertions
  property p_tmo_idle;
    @(posedge CLK_SYS) disable iff (!RST_N) tmo_ev |=> (st_r == sec_pkg::SEC_ST_IDLE) && !busy_r;
  endproperty
  a_tmo_idle: assert property (p_tmo_idle) else $error("timeout did not return idle");
  property p_tmo_flag;
    @(posedge CLK_SYS) disable iff (!RST_N) tmo_ev |=> tmo_r && stat_r[0];
  endproperty
  a_tmo_flag: assert property (p_tmo_flag) else $error("timeout flag not set");
  property p_no_wait;
    @(posedge CLK_SYS) disable iff (!RST_N)
      (st_r == sec_pkg::SEC_ST_DONE) && sh_done && !needs_wait |=> !busy_r;
  endproperty
  a_no_wait: assert property (p_no_wait) else $error("busy kept after shift");
  property p_wait_class;
    @(posedge CLK_SYS) disable iff (!RST_N) (st_r == sec_pkg::SEC_ST_WAIT) |-> wr_class;
  endproperty
  a_wait_class: assert property (p_wait_class) else $error("wrong command waits");
  property p_loaded;
    @(posedge CLK_SYS) disable iff (!RST_N) load_ev |=> loaded_r;
  endproperty
  a_loaded: assert property (p_loaded) else $error("loaded flag not set");
  property p_addr;
    @(posedge CLK_SYS) disable iff (!RST_N) cmd_wr && !busy_r |=> addr_r == $past(HWDATA[7:0]);
  endproperty
  a_addr: assert property (p_addr) else $error("address not taken");
  property p_unlock;
    @(posedge CLK_SYS) disable iff (!RST_N)
      (st_r == sec_pkg::SEC_ST_DONE) && sh_done && cmd_r == sec_pkg::SEC_CMD_UNLOCK |=> unlock_r;
  endproperty
  a_unlock: assert property (p_unlock) else $error("unlock not kept");
  property p_busy;
    @(posedge CLK_SYS) disable iff (!RST_N) (st_r != sec_pkg::SEC_ST_IDLE) |-> busy_r;
  endproperty
  a_busy: assert property (p_busy) else $error("busy dropped early");
  property p_boot;
    @(posedge CLK_SYS) disable iff (!RST_N) boot_r |=> busy_r && (cmd_r == sec_pkg::SEC_CMD_RELOAD);
  endproperty
  a_boot: assert property (p_boot) else $error("power-up load not started");
  property p_line_high;
    @(posedge CLK_SYS) disable iff (!RST_N)
      (st_r == sec_pkg::SEC_ST_WAIT) && din_s2_r |=> (st_r == sec_pkg::SEC_ST_IDLE) && !busy_r;
  endproperty
  a_line_high: assert property (p_line_high) else $error("busy kept with line high");
  c_boot: cover property (@(posedge CLK_SYS) disable iff (!RST_N) boot_r);
  c_timeout: cover property (@(posedge CLK_SYS) disable iff (!RST_N) tmo_ev);
  c_reload: cover property (@(posedge CLK_SYS) disable iff (!RST_N) load_ev);
  c_wait_ok: cover property (@(posedge CLK_SYS) disable iff (!RST_N)
    (st_r == sec_pkg::SEC_ST_WAIT) && din_s2_r);
endmodule : sec_ctrl
`default_nettype wire

/* File: test/sec_mem_model.sv */
// Behavioural model of the external serial memory
`timescale 1ns/1ns
`default_nettype none
module sec_mem_model #(
  parameter int RDY_CYC = 20
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cs,
  input wire logic sk,
  input wire logic di,
  input wire logic [1:0] mode,
  output logic dq,
  output logic [18:0] seen
);
  // ==========================================
  // Frame edge count, captured bits and ready timer
  logic sk_r;
  logic cs_r;
  logic [4:0] cnt_r;
  logic [18:0] seen_r;
  int tmr_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sk_r <= 1'b0;
      cs_r <= 1'b0;
      cnt_r <= 5'h00;
      seen_r <= 19'h00000;
      tmr_r <= 0;
    end else begin
      sk_r <= sk;
      cs_r <= cs;
      if (!cs) cnt_r <= 5'h00;
      else if (sk && !sk_r && cnt_r != 5'h1F) cnt_r <= cnt_r + 5'h01;
      if (cs && !cs_r) seen_r <= 19'h00000;
      else if (cs && sk && !sk_r) seen_r <= {seen_r[17:0], di};
      if (cs_r && !cs && cnt_r != 5'h00) tmr_r <= RDY_CYC;
      else if (tmr_r != 0) tmr_r <= tmr_r - 1;
    end
  end
  assign seen = seen_r;
  // ==========================================
  // Pin level: present, absent pulled high, absent pulled low
  always_comb begin
    case (mode)
      2'h1: dq = 1'b1;
      2'h2: dq = 1'b0;
      default: dq = !((tmr_r != 0) || (cs && cnt_r != 5'h00 && cnt_r < 5'h13));
    endcase
  end
endmodule : sec_mem_model
`default_nettype wire

/* File: test/testbench.sv */
// Testbench of the serial memory command controller
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin mismatches++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module testbench;
  logic CLK_SYS, RST_N, HWRITE, MEM_CS, MEM_SK, MEM_DO, IRQ, HREADYOUT, HRESP, PIN;
  logic [7:0] HADDR;
  logic [1:0] HTRANS, mode;
  logic [31:0] HWDATA, HRDATA, rd;
  logic [18:0] seen;
  int mismatches = 0;
  int checks = 0;
  sec_ctrl #(.TMO_CYC(50)) dut (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .HSEL(1'b1),
    .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA),
    .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
    .MEM_CS(MEM_CS), .MEM_SK(MEM_SK), .MEM_DO(MEM_DO), .SERIAL_MEM_DATA_PIN(PIN), .IRQ(IRQ));
  sec_mem_model mem (.clk(CLK_SYS), .rst_n(RST_N), .cs(MEM_CS), .sk(MEM_SK), .di(MEM_DO),
    .mode(mode), .dq(PIN), .seen(seen));
  // ==========================================
  // Bus and command tasks
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    HTRANS <= 2'h2;
    HADDR <= a;
    HWRITE <= w;
    do @(posedge CLK_SYS); while (HREADYOUT !== 1'b1);
    HTRANS <= 2'h0;
    HWDATA <= d;
    do @(posedge CLK_SYS); while (HREADYOUT !== 1'b1);
    rd = HRDATA;
  endtask : bus
  task automatic start(input logic [2:0] c);
    bus(1'b1, 8'h00, {1'b1, c, 20'h00000, 8'h3C});
    bus(1'b0, 8'h00, 32'h00000000);
    `CHK("busy", 1'b1, rd[31])
    for (int i = 0; i < 400 && rd[31] !== 1'b0; i++) bus(1'b0, 8'h00, 32'h00000000);
    `CHK("busy end", 1'b0, rd[31])
  endtask : start
  task automatic run(input logic [2:0] c, input logic tmo);
    start(c);
    `CHK("timeout", tmo, rd[9])
    bus(1'b1, 8'h00, 32'h0000023C);
    bus(1'b0, 8'h00, 32'h00000000);
    `CHK("timeout clr", 1'b0, rd[9])
  endtask : run
  // ==========================================
  // Scenarios
  task automatic t_reset();
    bus(1'b0, 8'h00, 32'h0);
    `CHK("boot busy", 1'b1, rd[31])
    for (int i = 0; i < 200 && rd[31] !== 1'b0; i++) bus(1'b0, 8'h00, 32'h0);
    `CHK("cmd rst", 32'h70000000, rd)
    `CHK("okay", 1'b0, HRESP)
    `CHK("ready", 1'b1, HREADYOUT)
    bus(1'b0, 8'h40, 32'h0);
    `CHK("unmapped", 32'h00000000, rd)
    bus(1'b1, 8'h00, 32'h000000A5);
    bus(1'b0, 8'h00, 32'h0);
    `CHK("addr rw", 32'h000000A5, rd)
    `CHK("cs idle", 1'b0, MEM_CS)
    $display("test reset done");
  endtask : t_reset
  task automatic t_high();
    mode <= 2'h1;
    for (int c = 0; c < 8; c++) run(c[2:0], 1'b0);
    `CHK("no load", 1'b0, rd[8])
    $display("test absent high done");
  endtask : t_high
  task automatic t_low();
    mode <= 2'h2;
    run(sec_pkg::SEC_CMD_UNLOCK, 1'b0);
    for (int c = 0; c < 8; c++) if (c > 2 || c == 0) run(c[2:0], c inside {[3:6]});
    run(sec_pkg::SEC_CMD_LOCK, 1'b0);
    run(sec_pkg::SEC_CMD_WRITE, 1'b0);
    run(sec_pkg::SEC_CMD_UNLOCK, 1'b0);
    run(sec_pkg::SEC_CMD_ERASE, 1'b1);
    `CHK("erase addr", 8'h3C, seen[7:0])
    `CHK("erase start", 1'b1, seen[10])
    `CHK("erase len", 8'h00, seen[18:11])
    $display("test absent low done");
  endtask : t_low
  task automatic t_irq();
    bus(1'b1, 8'h0C, 32'h1);
    bus(1'b1, 8'h00, {1'b1, sec_pkg::SEC_CMD_WRALL, 20'h00000, 8'h3C});
    bus(1'b1, 8'h00, 32'h00000077);
    start(sec_pkg::SEC_CMD_ERALL);
    `CHK("refused addr", 8'h3C, rd[7:0])
    `CHK("irq on", 1'b1, IRQ)
    bus(1'b1, 8'h0C, 32'h0);
    bus(1'b0, 8'h08, 32'h0);
    `CHK("irq stat", 1'b1, rd[0])
    `CHK("irq masked", 1'b0, IRQ)
    bus(1'b1, 8'h08, 32'h3);
    bus(1'b1, 8'h0C, 32'h1);
    bus(1'b0, 8'h08, 32'h0);
    `CHK("irq clr", 32'h00000000, rd)
    `CHK("irq off", 1'b0, IRQ)
    $display("test interrupt done");
  endtask : t_irq
  task automatic t_present();
    mode <= 2'h0;
    bus(1'b1, 8'h00, 32'h0000033C);
    start(sec_pkg::SEC_CMD_RELOAD);
    `CHK("loaded", 1'b1, rd[8])
    run(sec_pkg::SEC_CMD_WRITE, 1'b0);
    `CHK("frame start", 1'b1, seen[18])
    `CHK("frame addr", 8'h3C, seen[15:8])
    $display("test present done");
  endtask : t_present
  // ==========================================
  // Clock, reset, sequence and verdict
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : report_and_stop
  initial begin
    CLK_SYS = 1'b0;
    forever #50 CLK_SYS = !CLK_SYS;
  end
  initial begin
    #2000000;
    mismatches++;
    report_and_stop();
  end
  initial begin
    RST_N = 1'b0;
    HADDR = 8'h00;
    HTRANS = 2'h0;
    HWRITE = 1'b0;
    HWDATA = 32'h0;
    mode = 2'h1;
    repeat (3) @(posedge CLK_SYS);
    RST_N <= 1'b1;
    @(posedge CLK_SYS);
    t_reset();
    t_high();
    t_low();
    t_irq();
    t_present();
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
